// ---- irq_bank_regs.svh ----
// register offsets, field positions, command codes and reset values of the interrupt bank
`ifndef IRQ_BANK_REGS_SVH
`define IRQ_BANK_REGS_SVH

// ********************************
// register byte offsets
// ********************************
`define OFS_CTRL 8'h00
`define OFS_MASK 8'h04
`define OFS_CMD 8'h08
`define OFS_STATUS 8'h0C
// vector words live at 0x20..0x3C, selected by address bits above bit 4
`define VEC_BLOCK 8'h01
`define VEC_BLOCK_SHIFT 5

// ********************************
// control word fields
// ********************************
`define CTRL_LEVEL_BIT 0
`define CTRL_SMM_BIT 1
`define CTRL_AUTO_END_OF_SERVICE_MODE_BIT 2
`define CTRL_ROT_AUTO_END_OF_SERVICE_MODE_BIT 3

// ********************************
// command word fields and codes
// ********************************
`define CMD_CODE_MSB 6
`define CMD_CODE_LSB 4
`define CMD_LVL_MSB 2
`define CMD_NOP 3'h0
`define CMD_NSEOI 3'h1
`define CMD_SEOI 3'h2
`define CMD_ROT_NSEOI 3'h3
`define CMD_ROT_SEOI 3'h4
`define CMD_SET_PRIO 3'h5
`define CMD_ROT_AUTO_END_OF_SERVICE_MODE_SET 3'h6
`define CMD_ROT_AUTO_END_OF_SERVICE_MODE_CLR 3'h7

// ********************************
// reset values
// ********************************
`define RST_BASE 3'h7
`define RST_MASK 8'h00
`define RST_VEC 8'h00
`define RST_REQ_PREV 8'hFF

`endif

// ---- irq_bank_pkg.sv ----
// types shared by the interrupt bank modules
`default_nettype none
package irq_bank_pkg;
    typedef logic [2:0] level_t;
    typedef logic [7:0] byte_t;
    typedef enum logic {ACK_IDLE, ACK_WAIT_SECOND} ack_phase_t;
endpackage
`default_nettype wire

// ---- prio_if.sv ----
// carrier between the bank and its rotating priority pickers
`default_nettype none
interface prio_if;
    import irq_bank_pkg::*;
    logic [7:0] vec;
    level_t base;
    logic found;
    level_t idx;
    level_t rank;
    modport pick(input vec, input base, output found, output idx, output rank);
    modport user(output vec, output base, input found, input idx, input rank);
endinterface
`default_nettype wire

// ---- prio_pick.sv ----
// rotating priority picker: highest-ranked set bit after the lowest level
`default_nettype none
module prio_pick (
    prio_if.pick p
);
    import irq_bank_pkg::*;

    // ********************************
    // circular scan
    // ********************************
    // wrap after lowest level
    always_comb begin
        level_t lvl;
        lvl = 3'h0;
        p.found = 1'b0;
        p.idx = 3'h0;
        p.rank = 3'h7;
        for (int k = 7; k >= 0; k--) begin
            lvl = p.base + 3'h1 + 3'(k);
            if (p.vec[lvl]) begin
                p.found = 1'b1;
                p.idx = lvl;
                p.rank = 3'(k);
            end
        end
    end
endmodule
`default_nettype wire

// ---- irq_bank.sv ----
// eight-line interrupt bank with rotation, masking, cascade and avalon registers
`include "irq_bank_regs.svh"
`default_nettype none
module irq_bank #(
    parameter int ADDR_W = 6
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // request lines, active low
    input wire logic [7:0] req_n_i,
    // acknowledge cycles
    input wire logic ack_first_i,
    input wire logic ack_second_i,
    input wire irq_bank_pkg::byte_t default_vec_i,
    output irq_bank_pkg::byte_t data_o,
    output logic data_oe_n_o,
    output logic int_o
);
    import irq_bank_pkg::*;

    if (ADDR_W < 6) begin : g_addr_check
        $error("ADDR_W must be at least 6");
    end

    // ********************************
    // state
    // ********************************
    logic level_mode;
    logic smm;
    logic auto_end_of_service_mode;
    logic rot_auto_end_of_service_mode;
    logic [7:0] slave_map;
    logic [7:0] line_mask_reg;
    byte_t vec_reg [8];
    logic [7:0] pending_request_reg;
    logic [7:0] in_service_reg;
    level_t base;
    logic [7:0] req_prev_n;
    ack_phase_t phase;
    level_t win_q;
    logic slave_q;
    logic dflt_q;

    // ********************************
    // bus decode
    // ********************************
    wire bus_req = read_i | write_i;
    wire bus_go = bus_req & ~waitrequest_o;
    wire wr_go = write_i & bus_go;
    wire sel_ctrl = address_i == ADDR_W'(`OFS_CTRL);
    wire sel_mask = address_i == ADDR_W'(`OFS_MASK);
    wire sel_cmd = address_i == ADDR_W'(`OFS_CMD);
    wire sel_status = address_i == ADDR_W'(`OFS_STATUS);
    wire sel_vec = ((address_i >> `VEC_BLOCK_SHIFT) == ADDR_W'(`VEC_BLOCK))
        && (address_i[1:0] == 2'h0);
    wire level_t vec_idx = address_i[4:2];
    wire cmd_go = wr_go & sel_cmd & byteenable_i[0];
    wire [2:0] cmd_code = writedata_i[`CMD_CODE_MSB:`CMD_CODE_LSB];
    wire level_t cmd_lvl = writedata_i[`CMD_LVL_MSB:0];

    // ********************************
    // priority resolution
    // ********************************
    prio_if req_p ();
    prio_if isr_p ();
    prio_pick u_req_pick (.p(req_p));
    prio_pick u_isr_pick (.p(isr_p));

    wire [7:0] cand = pending_request_reg & ~line_mask_reg & (smm ? ~in_service_reg : 8'hFF);
    assign req_p.vec = cand;
    assign req_p.base = base;
    assign isr_p.vec = in_service_reg;
    assign isr_p.base = base;
    wire outranks = ~isr_p.found | smm | (req_p.rank < isr_p.rank);
    wire next_int = req_p.found & outranks;
    wire serve = ack_first_i & next_int & ~req_n_i[req_p.idx];
    wire [7:0] win_oh = 8'h01 << req_p.idx;
    wire [7:0] top_oh = 8'h01 << isr_p.idx;
    wire [7:0] lvl_oh = 8'h01 << cmd_lvl;

    // ********************************
    // end of service and rotation
    // ********************************
    wire second_go = ack_second_i & (phase == ACK_WAIT_SECOND);
    wire auto_eoi = second_go & ~dflt_q & (auto_end_of_service_mode | rot_auto_end_of_service_mode) & isr_p.found;
    wire cmd_top = cmd_go & ((cmd_code == `CMD_NSEOI) | (cmd_code == `CMD_ROT_NSEOI));
    wire cmd_spec = cmd_go & ((cmd_code == `CMD_SEOI) | (cmd_code == `CMD_ROT_SEOI));
    wire [7:0] isr_clr = ((cmd_top | auto_eoi) ? top_oh : 8'h00) | (cmd_spec ? lvl_oh : 8'h00);
    wire [7:0] isr_set = serve ? win_oh : 8'h00;
    // set wins over clear
    wire [7:0] next_isr = (in_service_reg & ~isr_clr) | isr_set;
    wire rot_to_top = cmd_go & (cmd_code == `CMD_ROT_NSEOI) & isr_p.found;
    wire rot_to_lvl = cmd_go & ((cmd_code == `CMD_ROT_SEOI) | (cmd_code == `CMD_SET_PRIO));
    wire rot_auto = auto_eoi & rot_auto_end_of_service_mode;
    wire level_t next_base = rot_to_lvl ? cmd_lvl :
        rot_to_top ? isr_p.idx :
        rot_auto ? isr_p.idx : base;

    // ********************************
    // request capture
    // ********************************
    // falling edge only
    wire [7:0] edge_set = req_prev_n & ~req_n_i;
    wire [7:0] pend_clr = serve ? win_oh : 8'h00;
    wire [7:0] next_pending = level_mode ? ~req_n_i :
        ((pending_request_reg & ~pend_clr) | edge_set);

    // ********************************
    // read mux
    // ********************************
    wire [31:0] ctrl_word = {16'h0000, slave_map, 4'h0, rot_auto_end_of_service_mode, auto_end_of_service_mode, smm, level_mode};
    wire [31:0] status_word = {12'h000, int_o, base, in_service_reg, pending_request_reg};
    wire [31:0] next_rdata = sel_ctrl ? ctrl_word :
        sel_mask ? {24'h000000, line_mask_reg} :
        sel_status ? status_word :
        sel_vec ? {24'h000000, vec_reg[vec_idx]} : 32'h00000000;

    // ********************************
    // acknowledge data
    // ********************************
    // cascade address or zero
    wire byte_t first_byte = (serve & slave_map[req_p.idx]) ? vec_reg[req_p.idx] : 8'h00;
    wire byte_t second_byte = dflt_q ? default_vec_i : vec_reg[win_q];

    // ********************************
    // avalon slave
    // ********************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            waitrequest_o <= 1'b1;
            readdata_o <= 32'h00000000;
        end else begin
            waitrequest_o <= ~(bus_req & waitrequest_o);
            if (bus_req & waitrequest_o) begin
                readdata_o <= read_i ? next_rdata : 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            level_mode <= 1'b0;
            smm <= 1'b0;
            auto_end_of_service_mode <= 1'b0;
            slave_map <= 8'h00;
            line_mask_reg <= `RST_MASK;
        end else if (wr_go) begin
            if (sel_ctrl & byteenable_i[0]) begin
                level_mode <= writedata_i[`CTRL_LEVEL_BIT];
                smm <= writedata_i[`CTRL_SMM_BIT];
                auto_end_of_service_mode <= writedata_i[`CTRL_AUTO_END_OF_SERVICE_MODE_BIT];
            end
            if (sel_ctrl & byteenable_i[1]) begin
                slave_map <= writedata_i[15:8];
            end
            if (sel_mask & byteenable_i[0]) begin
                line_mask_reg <= writedata_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < 8; i++) begin
                vec_reg[i] <= `RST_VEC;
            end
        end else if (wr_go & sel_vec & byteenable_i[0]) begin
            vec_reg[vec_idx] <= writedata_i[7:0];
        end
    end

    // rotate auto eoi set and clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rot_auto_end_of_service_mode <= 1'b0;
        end else if (cmd_go & (cmd_code == `CMD_ROT_AUTO_END_OF_SERVICE_MODE_SET)) begin
            rot_auto_end_of_service_mode <= 1'b1;
        end else if (cmd_go & (cmd_code == `CMD_ROT_AUTO_END_OF_SERVICE_MODE_CLR)) begin
            rot_auto_end_of_service_mode <= 1'b0;
        end
    end

    // ********************************
    // core state
    // ********************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pending_request_reg <= 8'h00;
            in_service_reg <= 8'h00;
            base <= `RST_BASE;
            req_prev_n <= `RST_REQ_PREV;
            int_o <= 1'b0;
        end else begin
            pending_request_reg <= next_pending;
            in_service_reg <= next_isr;
            base <= next_base;
            req_prev_n <= req_n_i;
            int_o <= next_int;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            phase <= ACK_IDLE;
            win_q <= 3'h0;
            slave_q <= 1'b0;
            dflt_q <= 1'b0;
            data_o <= 8'h00;
            data_oe_n_o <= 1'b1;
        end else begin
            case (phase)
                ACK_IDLE: begin
                    if (ack_first_i) begin
                        phase <= ACK_WAIT_SECOND;
                    end
                end
                ACK_WAIT_SECOND: begin
                    if (ack_second_i) begin
                        phase <= ACK_IDLE;
                    end
                end
                default: begin
                    phase <= ACK_IDLE;
                end
            endcase
            data_oe_n_o <= 1'b1;
            data_o <= 8'h00;
            if (ack_first_i) begin
                win_q <= req_p.idx;
                slave_q <= serve & slave_map[req_p.idx];
                dflt_q <= ~serve;
                data_o <= first_byte;
                data_oe_n_o <= 1'b0;
            end else if (second_go) begin
                data_o <= slave_q ? 8'h00 : second_byte;
                data_oe_n_o <= slave_q;
            end
        end
    end

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence rot_top_cmd;
        cmd_go && (cmd_code == `CMD_ROT_NSEOI) && isr_p.found && !ack_first_i;
    endsequence
    sequence plain_top_cmd;
        cmd_go && (cmd_code == `CMD_NSEOI) && isr_p.found && !ack_first_i && !auto_eoi;
    endsequence
    sequence miss_first;
        ack_first_i && !serve;
    endsequence
    sequence slave_first;
        serve && slave_map[req_p.idx];
    endsequence
    sequence lone_second;
        ack_second_i && !ack_first_i;
    endsequence

    rot_top_eoi_a: assert property (rot_top_cmd |=>
        (base == $past(isr_p.idx)) && !in_service_reg[$past(isr_p.idx)])
        else $error("rotate eoi did not clear and rotate");
    set_prio_lvl_a: assert property (
        cmd_go && (cmd_code == `CMD_SET_PRIO) |=> base == $past(cmd_lvl))
        else $error("set priority did not move lowest level");
    rot_spec_eoi_a: assert property (
        cmd_go && (cmd_code == `CMD_ROT_SEOI) && !ack_first_i |=>
        (base == $past(cmd_lvl)) && !in_service_reg[$past(cmd_lvl)])
        else $error("rotate specific eoi failed");
    nested_eoi_a: assert property (plain_top_cmd |=>
        (base == $past(base)) && !in_service_reg[$past(isr_p.idx)])
        else $error("plain eoi changed priority or missed bit");
    mask_gate_int_a: assert property (
        int_o |-> ($past(pending_request_reg) & ~$past(line_mask_reg)) != 8'h00)
        else $error("interrupt without unmasked pending request");
    nest_block_a: assert property (
        int_o && $past(isr_p.found) && !$past(smm) |->
        3'($past(req_p.idx) - $past(base) - 3'h1) < 3'($past(isr_p.idx) - $past(base) - 3'h1))
        else $error("interrupt from equal or lower level");
    edge_once_a: assert property (
        !level_mode && $stable(req_n_i) && !ack_first_i |=>
        (pending_request_reg & ~$past(pending_request_reg)) == 8'h00)
        else $error("held input made a new edge request");
    level_follow_a: assert property (
        level_mode |=> pending_request_reg == ~$past(req_n_i))
        else $error("level mode pending does not follow input");
    default_vec_a: assert property (miss_first ##[1:8] lone_second |=>
        (data_o == $past(default_vec_i)) && !data_oe_n_o)
        else $error("missed request did not give default vector");
    first_zero_a: assert property (
        serve && !slave_map[req_p.idx] |=> (data_o == 8'h00) && !data_oe_n_o)
        else $error("non-slave first ack did not drive zero");
    slave_float_a: assert property (slave_first ##[1:8] lone_second |=>
        data_oe_n_o && (data_o == 8'h00))
        else $error("bus driven during slave second ack");
    auto_eoi_clear_a: assert property (
        auto_eoi && !rot_auto_end_of_service_mode && !cmd_go && !ack_first_i |=>
        !in_service_reg[$past(isr_p.idx)] && (base == $past(base)))
        else $error("auto eoi did not clear top bit");
    rot_auto_a: assert property (
        auto_eoi && rot_auto_end_of_service_mode && !cmd_go |=> base == $past(isr_p.idx))
        else $error("rotate auto eoi did not rotate");
endmodule
`default_nettype wire

// ---- host_side_model.sv ----
// host acknowledge cycles, cascade address latch and one external slave
`default_nettype none
module host_side_model #(
    parameter logic [7:0] SLAVE_XOR = 8'h80,
    parameter int ACK_GAP = 4
) (
    // clock
    input wire logic clk_i,
    // device acknowledge data
    input wire logic [7:0] data_i,
    input wire logic data_oe_n_i,
    // acknowledge strobes
    output logic ack_first_o,
    output logic ack_second_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************
    // acknowledge sequence
    // ********************************
    logic [7:0] bus_last = 8'h00;
    logic [7:0] cas_addr = 8'h00;
    logic [7:0] first_b = 8'h00;
    logic [7:0] second_b = 8'h00;
    logic second_oe_n = 1'b1;
    initial begin
        ack_first_o = 1'b0;
        ack_second_o = 1'b0;
    end
    // level seen on the shared data bus
    function automatic logic [7:0] bus_level(input logic sel_slave);
        if (!data_oe_n_i) begin
            return data_i;
        end
        if (sel_slave) begin
            return cas_addr ^ SLAVE_XOR;
        end
        return ~bus_last;
    endfunction
    task automatic run_ack();
        @(posedge clk_i);
        ack_first_o <= 1'b1;
        @(posedge clk_i);
        ack_first_o <= 1'b0;
        @(posedge clk_i);
        first_b = bus_level(1'b0);
        bus_last = first_b;
        cas_addr = data_oe_n_i ? 8'h00 : data_i;
        repeat (ACK_GAP) @(posedge clk_i);
        ack_second_o <= 1'b1;
        @(posedge clk_i);
        ack_second_o <= 1'b0;
        @(posedge clk_i);
        second_oe_n = data_oe_n_i;
        second_b = bus_level(cas_addr != 8'h00);
        bus_last = second_b;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the eight-line interrupt bank
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_bank_pkg::*;
    // ********************************
    // stimulus and checks
    // ********************************
    typedef struct packed {logic [7:0] mask; logic [7:0] req; logic irq; logic [7:0] vec;} row_t;
    row_t rows [6] = '{
        '{8'h00, 8'hFE, 1'b1, 8'h40},
        '{8'h00, 8'h7F, 1'b1, 8'h47},
        '{8'h00, 8'h5A, 1'b1, 8'h40},
        '{8'h01, 8'hFC, 1'b1, 8'h41},
        '{8'hFF, 8'h00, 1'b0, 8'hDE},
        '{8'h80, 8'h7F, 1'b0, 8'hDE}};
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [5:0] address_i = 6'h00;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    logic [7:0] req_n_i = 8'hFF;
    logic ack_first_i;
    logic ack_second_i;
    byte_t default_vec_i = 8'hDE;
    byte_t data_o;
    logic data_oe_n_o;
    logic int_o;
    logic [31:0] q;
    int err_total = 0;
    int checks = 0;
    irq_bank #(.ADDR_W(6)) dut_u (.clk_i(clk_i), .srst_i(srst_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'h3),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .req_n_i(req_n_i),
        .ack_first_i(ack_first_i), .ack_second_i(ack_second_i), .default_vec_i(default_vec_i),
        .data_o(data_o), .data_oe_n_o(data_oe_n_o), .int_o(int_o));
    host_side_model host_u (.clk_i(clk_i), .data_i(data_o), .data_oe_n_i(data_oe_n_o),
        .ack_first_o(ack_first_i), .ack_second_o(ack_second_i));
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address_i <= a;
        writedata_i <= d;
        write_i <= wr;
        read_i <= ~wr;
        @(posedge clk_i);
        while (waitrequest_o !== 1'b0) begin
            n++;
            if (n > 20) begin
                err_total++;
                print_verdict();
            end
            @(posedge clk_i);
        end
        q = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [5:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic cmd(input logic [2:0] c, input logic [2:0] l);
        bus(1'b1, 6'h08, {25'h0, c, 1'b0, l});
    endtask
    task automatic ack(input logic [7:0] f, input logic [7:0] s, input logic oe2);
        host_u.run_ack();
        chk(host_u.first_b, f);
        chk(host_u.second_b, s);
        chk(host_u.second_oe_n, oe2);
    endtask
    task automatic svc(input logic [7:0] r, input logic [7:0] v);
        req_n_i <= r;
        cyc(4);
        chk(int_o, 1'b1);
        ack(8'h00, v, 1'b0);
        req_n_i <= 8'hFF;
        cyc(1);
    endtask
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        print_verdict();
    end
    initial begin
        cyc(8);
        srst_i <= 1'b0;
        cyc(1);
        rd(6'h00);
        chk(q, 32'h0);
        rd(6'h0C);
        chk(q, 32'h00070000);
        chk(int_o, 1'b0);
        bus(1'b1, 6'h10, 32'hFF);
        rd(6'h10);
        chk(q, 32'h0);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 6'h20 + 6'(4 * i), 32'h40 + 32'(i));
        end
        rd(6'h24);
        chk(q, 32'h41);
        bus(1'b1, 6'h00, 32'h1);
        foreach (rows[i]) begin
            bus(1'b1, 6'h04, {24'h0, rows[i].mask});
            req_n_i <= rows[i].req;
            cyc(4);
            chk(int_o, rows[i].irq);
            ack(8'h00, rows[i].vec, 1'b0);
            req_n_i <= 8'hFF;
            cmd(3'h1, 3'h0);
        end
        bus(1'b1, 6'h04, 32'h0);
        svc(8'hEF, 8'h44);
        cmd(3'h3, 3'h0);
        rd(6'h0C);
        chk(q[18:8], 11'h400);
        svc(8'hD7, 8'h45);
        cmd(3'h1, 3'h0);
        rd(6'h0C);
        chk(q[18:8], 11'h400);
        cmd(3'h5, 3'h6);
        svc(8'h7E, 8'h47);
        cmd(3'h1, 3'h0);
        cmd(3'h5, 3'h7);
        svc(8'h7E, 8'h40);
        cmd(3'h4, 3'h0);
        rd(6'h0C);
        chk(q[18:8], 11'h000);
        cmd(3'h5, 3'h7);
        svc(8'hFB, 8'h42);
        req_n_i <= 8'hBF;
        cyc(4);
        chk(int_o, 1'b0);
        bus(1'b1, 6'h00, 32'h3);
        cyc(4);
        chk(int_o, 1'b1);
        ack(8'h00, 8'h46, 1'b0);
        req_n_i <= 8'hFF;
        cmd(3'h2, 3'h6);
        cmd(3'h2, 3'h2);
        bus(1'b1, 6'h00, 32'h1);
        cmd(3'h6, 3'h0);
        rd(6'h00);
        chk(q[3], 1'b1);
        svc(8'hFD, 8'h41);
        rd(6'h0C);
        chk(q[18:8], 11'h100);
        cmd(3'h7, 3'h0);
        rd(6'h00);
        chk(q[3], 1'b0);
        svc(8'hFD, 8'h41);
        rd(6'h0C);
        chk(q[15:8], 8'h02);
        cmd(3'h1, 3'h0);
        cmd(3'h5, 3'h7);
        bus(1'b1, 6'h00, 32'h5);
        svc(8'hFE, 8'h40);
        rd(6'h0C);
        chk(q[18:8], 11'h700);
        bus(1'b1, 6'h04, 32'h08);
        req_n_i <= 8'hF7;
        cyc(4);
        chk(int_o, 1'b0);
        rd(6'h0C);
        chk(q[7:0], 8'h08);
        bus(1'b1, 6'h04, 32'h0);
        cyc(3);
        chk(int_o, 1'b1);
        req_n_i <= 8'hFF;
        ack(8'h00, 8'hDE, 1'b0);
        bus(1'b1, 6'h00, 32'h0);
        req_n_i <= 8'hF7;
        cyc(4);
        chk(int_o, 1'b1);
        ack(8'h00, 8'h43, 1'b0);
        cmd(3'h1, 3'h0);
        cyc(3);
        chk(int_o, 1'b0);
        req_n_i <= 8'hFF;
        cyc(2);
        req_n_i <= 8'hF7;
        cyc(4);
        chk(int_o, 1'b1);
        ack(8'h00, 8'h43, 1'b0);
        req_n_i <= 8'hFF;
        cmd(3'h1, 3'h0);
        bus(1'b1, 6'h00, 32'h2001);
        req_n_i <= 8'hDF;
        cyc(4);
        ack(8'h45, 8'hC5, 1'b1);
        req_n_i <= 8'hFF;
        cmd(3'h1, 3'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
